// File: rtl/rss_defs.svh
// Constants for the regulator start-up sequencer: timings, codes, offsets.
// Assumes a 25 MHz core clock; every count below is derived from it.
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH

`define RSS_CLK_MHZ 25
`define RSS_CLK_HZ 25000000
// Least times round up to whole cycles.
`define RSS_CYC_UP(ns) ((((ns) * `RSS_CLK_MHZ) + 999) / 1000)

`define RSS_INIT_DLY_NS 1400000
`define RSS_INIT_DLY_CYC `RSS_CYC_UP(`RSS_INIT_DLY_NS)
`define RSS_BOOT_HOLD_NS 85000
`define RSS_BOOT_HOLD_CYC `RSS_CYC_UP(`RSS_BOOT_HOLD_NS)
`define RSS_CODE_VALID_NS 500
`define RSS_CODE_VALID_CYC `RSS_CYC_UP(`RSS_CODE_VALID_NS)
`define RSS_A_GOOD_NS 440000
`define RSS_A_GOOD_CYC `RSS_CYC_UP(`RSS_A_GOOD_NS)
`define RSS_B_START_NS 1000000
`define RSS_B_START_CYC `RSS_CYC_UP(`RSS_B_START_NS)
`define RSS_B_GOOD_NS 1500000
`define RSS_B_GOOD_CYC `RSS_CYC_UP(`RSS_B_GOOD_NS)
`define RSS_STEP_HZ 330000
`define RSS_STEP_CYC (`RSS_CLK_HZ / `RSS_STEP_HZ)

// One DAC step is 6.25 mV; 176 steps make the 1.1 V boot level.
`define RSS_DAC_W 9
`define RSS_BOOT_CODE 9'h0B0
`define RSS_DAC_MAX 9'h1FF
`define RSS_NO_LOAD_CODE 5'h1F

`define RSS_PIN_LPOR 0
`define RSS_PIN_DPOR 1
`define RSS_PIN_EN 2
`define RSS_PIN_FBHI 3
`define RSS_PIN_RGND 4
`define RSS_PIN_OSC 5
`define RSS_PIN_WIN 6
`define RSS_PIN_CODE_LSB 7
`define RSS_PIN_MODE_LSB 15
`define RSS_PIN_W 17

`define RSS_REG_CTRL 4'h0
`define RSS_REG_STAT 4'h1
`define RSS_REG_DAC 4'h2
`define RSS_CTRL_RST 16'h0000
`define RSS_REG_W 16

`endif

// File: rtl/rss_pkg.sv
// Types shared by the start-up sequencer modules.
// Assumes nothing of its surroundings.
package rss_pkg;

  typedef enum logic [1:0] {
    RSS_MODE_A10,
    RSS_MODE_A11,
    RSS_MODE_B6,
    RSS_MODE_B5
  } rss_mode_e;

  typedef enum logic [3:0] {
    ST_SHUT,
    ST_A_DELAY,
    ST_A_RAMP1,
    ST_A_HOLD,
    ST_A_RAMP2,
    ST_B_DELAY,
    ST_B_RAMP,
    ST_GOOD_WAIT,
    ST_RUN
  } rss_state_e;

endpackage

// File: rtl/rss_pin_if.sv
// Raw and qualified pin levels passed between the sequencer and its
// input qualifier. Assumes one clock domain for the qualified side.
`timescale 1ns/100ps
interface rss_pin_if #(
  parameter int W = 1
);
  logic [W-1:0] raw;
  logic [W-1:0] clean;

  modport qual (
    input raw,
    output clean
  );

  modport user (
    output raw,
    input clean
  );
endinterface

// File: rtl/rss_pin_qual.sv
// Input qualifier: each pin passes three flip-flops and its clean level
// moves only once the second and third stages agree.
// Assumes asynchronous pins and a synchronous active-low reset.
`timescale 1ns/100ps
module rss_pin_qual #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  rss_pin_if.qual pins
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] clean_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    // The first stage feeds only the second, never any logic.
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
        s3_q[i] <= 1'b0;
        clean_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= pins.raw[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          clean_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign pins.clean = clean_q;

endmodule

// File: rtl/rss_sequencer.sv
// Start-up sequencer for a two-phase buck controller: qualifies supply
// and enable, steps the reference DAC, gates drivers and power-good.
// Assumes asynchronous pins, a decoded level on the code pins and a
// plain register port clocked by CORE_CLK.
//
// How it works
// - In shutdown the PWM outputs are released to high impedance.
// - Shutdown holds until the logic supply passed its rising threshold.
// - Shutdown holds until the driver supply passed its rising threshold.
// - Shutdown holds until the enable comparator reports enable high.
// - Family A and 6-bit family B start as soon as conditions hold.
// - 5-bit family B never starts while the code is all ones.
// - Family A soft-start opens with a fixed 1.40 ms delay.
// - Family A then ramps to the 1.1 V boot level and holds.
// - Boot level is held at least 85 us and until the code is valid.
// - Code validation takes at least 500 ns of stable code.
// - A valid sampled code starts a second ramp to code plus offset.
// - Family A ramps move one 6.25 mV step per oscillator tick.
// - Grounded rate pin makes family A step at 330 kHz.
// - Family A raises power-good 440 us after reaching the code.
// - Family B samples the code at start, then waits before ramping.
// - Family B ramps in 6.25 mV steps at a fixed 330 kHz.
// - Family B raises power-good 1.5 ms after reaching the code.
// - Drivers stay off while feedback exceeds the ramping reference.
// - A pre-charged output gets its drivers at soft-start end.
// - Power-good stays low in shutdown and soft-start.
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/100ps
`include "rss_defs.svh"
module rss_sequencer #(
  parameter logic [15:0] INIT_DLY_CYC = 16'(`RSS_INIT_DLY_CYC),
  parameter logic [15:0] A_GOOD_CYC = 16'(`RSS_A_GOOD_CYC),
  parameter logic [15:0] B_START_CYC = 16'(`RSS_B_START_CYC),
  parameter logic [15:0] B_GOOD_CYC = 16'(`RSS_B_GOOD_CYC)
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic LOGIC_POR_OK,
  input wire logic DRIVER_POR_OK,
  input wire logic ENABLE_OK,
  input wire logic FEEDBACK_ABOVE_REF,
  input wire logic SS_RATE_GROUNDED,
  input wire logic STEP_OSC,
  input wire logic OUTPUT_IN_LIMITS,
  input wire logic [7:0] VOLTAGE_ID_CODE,
  input wire rss_pkg::rss_mode_e MODE,
  input wire logic [3:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  output logic [8:0] DAC_CODE,
  output logic DRIVER_ENABLE,
  output logic PWM_OE_N,
  output logic POWER_GOOD_FLAG
);
  import rss_pkg::*;

  localparam logic [15:0] HOLD_CYC = 16'(`RSS_BOOT_HOLD_CYC);
  localparam logic [3:0] VALID_CYC = 4'(`RSS_CODE_VALID_CYC);
  localparam logic [6:0] STEP_CYC = 7'(`RSS_STEP_CYC);

  rss_pin_if #(.W(`RSS_PIN_W)) pins ();

  rss_pin_qual #(.W(`RSS_PIN_W)) u_qual (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .pins(pins)
  );

  assign pins.raw = {MODE, VOLTAGE_ID_CODE, OUTPUT_IN_LIMITS, STEP_OSC,
                     SS_RATE_GROUNDED, FEEDBACK_ABOVE_REF, ENABLE_OK,
                     DRIVER_POR_OK, LOGIC_POR_OK};

  wire lpor_ok = pins.clean[`RSS_PIN_LPOR];
  wire dpor_ok = pins.clean[`RSS_PIN_DPOR];
  wire en_ok = pins.clean[`RSS_PIN_EN];
  wire fb_high = pins.clean[`RSS_PIN_FBHI];
  wire rate_gnd = pins.clean[`RSS_PIN_RGND];
  wire osc_lvl = pins.clean[`RSS_PIN_OSC];
  wire win_ok = pins.clean[`RSS_PIN_WIN];
  wire [7:0] vcode = pins.clean[`RSS_PIN_CODE_LSB +: 8];
  rss_mode_e mode;
  assign mode = rss_mode_e'(pins.clean[`RSS_PIN_MODE_LSB +: 2]);

  rss_state_e st_q;
  rss_state_e st_d;
  logic [15:0] tmr_q;
  logic [15:0] tmr_d;
  logic [8:0] dac_q;
  logic [8:0] dac_d;
  logic [8:0] tgt_q;
  logic [8:0] tgt_d;
  logic [7:0] code_prev_q;
  logic [3:0] stab_q;
  logic [6:0] step_cnt_q;
  logic osc_prev_q;
  logic drv_q;
  logic oe_n_q;
  logic pg_q;
  logic [15:0] ctrl_q;
  logic [15:0] rdata_q;

  // Start conditions; any one lost drops the sequencer to shutdown.
  wire supplies_ok = lpor_ok & dpor_ok & en_ok;
  wire no_load = (mode == RSS_MODE_B5) &&
                 (vcode[4:0] == `RSS_NO_LOAD_CODE);
  wire start_ok = supplies_ok & ~no_load;
  wire fam_b = (mode == RSS_MODE_B6) || (mode == RSS_MODE_B5);

  // Target is the decoded level plus a software offset, clamped to range.
  wire [9:0] offs_sum = {2'b00, vcode} +
                        {{2{ctrl_q[7]}}, ctrl_q[7:0]};
  // A negative sum clamps to zero; the largest sum still fits in nine bits.
  wire [8:0] code_tgt = offs_sum[9] ? 9'h000 :
                        offs_sum[8:0];

  // A nonzero code counts as valid once it has stood unchanged long enough.
  wire code_valid = (stab_q == VALID_CYC) && (vcode != 8'h00);

  // Family A uses the external oscillator unless its rate pin is grounded.
  wire int_tick = (step_cnt_q == STEP_CYC - 7'h01);
  wire osc_tick = osc_lvl & ~osc_prev_q;
  wire use_osc = ~fam_b & ~rate_gnd;
  wire step_tick = use_osc ? osc_tick : int_tick;

  wire ramping = (st_q == ST_A_RAMP1) || (st_q == ST_A_RAMP2) ||
                 (st_q == ST_B_RAMP);
  wire [8:0] ramp_tgt = (st_q == ST_A_RAMP1) ? `RSS_BOOT_CODE : tgt_q;
  wire at_tgt = (dac_q == ramp_tgt);
  wire step_up = ramping & step_tick & (dac_q < ramp_tgt);
  wire step_dn = ramping & step_tick & (dac_q > ramp_tgt);
  wire [15:0] good_cyc = fam_b ? B_GOOD_CYC : A_GOOD_CYC;

  always_comb begin
    st_d = st_q;
    tgt_d = tgt_q;
    case (st_q)
      ST_SHUT: begin
        if (start_ok) begin
          if (fam_b) begin
            st_d = ST_B_DELAY;
            tgt_d = code_tgt;
          end else begin
            st_d = ST_A_DELAY;
          end
        end
      end
      ST_A_DELAY: begin
        if (tmr_q == INIT_DLY_CYC - 16'h0001) begin
          st_d = ST_A_RAMP1;
        end
      end
      ST_A_RAMP1: begin
        if (at_tgt) begin
          st_d = ST_A_HOLD;
        end
      end
      ST_A_HOLD: begin
        if ((tmr_q >= HOLD_CYC - 16'h0001) && code_valid) begin
          st_d = ST_A_RAMP2;
          tgt_d = code_tgt;
        end
      end
      ST_B_DELAY: begin
        if (tmr_q == B_START_CYC - 16'h0001) begin
          st_d = ST_B_RAMP;
        end
      end
      ST_A_RAMP2, ST_B_RAMP: begin
        if (at_tgt) begin
          st_d = ST_GOOD_WAIT;
        end
      end
      ST_GOOD_WAIT: begin
        if (tmr_q == good_cyc - 16'h0001) begin
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        st_d = ST_RUN;
      end
      default: begin
        st_d = ST_SHUT;
      end
    endcase
    if (!start_ok) begin
      st_d = ST_SHUT;
    end
  end

  // The timer restarts on every state change and saturates, so a long hold
  // waiting for a code cannot wrap into a false match.
  assign tmr_d = (st_d != st_q) ? 16'h0000 :
                 (tmr_q == 16'hFFFF) ? tmr_q : tmr_q + 16'h0001;

  assign dac_d = (st_d == ST_SHUT) ? 9'h000 :
                 step_up ? dac_q + 9'h001 :
                 step_dn ? dac_q - 9'h001 : dac_q;

  // Drivers come on once the reference overtakes the feedback, or at the
  // end of soft-start for an output charged above the final level.
  wire drv_d = (st_d != ST_SHUT) &&
               (drv_q || !fb_high || (st_d == ST_GOOD_WAIT) ||
                (st_d == ST_RUN));
  wire pg_d = (st_d == ST_RUN) && win_ok;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      st_q <= ST_SHUT;
      tmr_q <= 16'h0000;
      dac_q <= 9'h000;
      tgt_q <= 9'h000;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      dac_q <= dac_d;
      tgt_q <= tgt_d;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      code_prev_q <= 8'h00;
      stab_q <= 4'h0;
      step_cnt_q <= 7'h00;
      osc_prev_q <= 1'b0;
    end else begin
      code_prev_q <= vcode;
      if (vcode != code_prev_q) begin
        stab_q <= 4'h0;
      end else if (stab_q != VALID_CYC) begin
        stab_q <= stab_q + 4'h1;
      end
      step_cnt_q <= (int_tick || st_q == ST_SHUT) ? 7'h00 :
                    step_cnt_q + 7'h01;
      osc_prev_q <= osc_lvl;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      drv_q <= 1'b0;
      oe_n_q <= 1'b1;
      pg_q <= 1'b0;
    end else begin
      drv_q <= drv_d;
      oe_n_q <= (st_d == ST_SHUT);
      pg_q <= pg_d;
    end
  end

  // Register port: one writable control word, two read-only views.
  wire sel_ctrl = (REG_ADDR == `RSS_REG_CTRL);
  wire sel_stat = (REG_ADDR == `RSS_REG_STAT);
  wire sel_dac = (REG_ADDR == `RSS_REG_DAC);
  wire [15:0] stat_word = {8'h00, pg_q, drv_q, oe_n_q, fam_b, st_q};
  wire [15:0] rd_mux = sel_ctrl ? ctrl_q :
                       sel_stat ? stat_word :
                       sel_dac ? {7'h00, dac_q} : 16'h0000;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ctrl_q <= `RSS_CTRL_RST;
      rdata_q <= 16'h0000;
    end else begin
      if (REG_WR && sel_ctrl) begin
        ctrl_q <= {8'h00, REG_WDATA[7:0]};
      end
      rdata_q <= REG_RD ? rd_mux : 16'h0000;
    end
  end

  assign REG_RDATA = rdata_q;
  assign DAC_CODE = dac_q;
  assign DRIVER_ENABLE = drv_q;
  assign PWM_OE_N = oe_n_q;
  assign POWER_GOOD_FLAG = pg_q;

  AST_SHUT_HIZ: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (st_q == ST_SHUT) |-> PWM_OE_N && !DRIVER_ENABLE)
    else $error("PWM outputs driven during shutdown");

  AST_LOGIC_POR: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !lpor_ok |=> (st_q == ST_SHUT))
    else $error("Left shutdown without logic supply");

  AST_DRV_POR: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !dpor_ok |=> (st_q == ST_SHUT) && PWM_OE_N)
    else $error("Left shutdown without driver supply");

  AST_ENABLE: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    $fell(en_ok) |=> (st_q == ST_SHUT) && (dac_q == 9'h000))
    else $error("Enable loss did not reach shutdown");

  AST_NO_LOAD: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (st_q == ST_SHUT) && no_load |=> (st_q == ST_SHUT))
    else $error("Soft-start began on the no-load code");

  AST_QUICK_START: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (st_q == ST_SHUT) && start_ok |=> (st_q != ST_SHUT))
    else $error("Start conditions met but start delayed");

  AST_INIT_DELAY: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (st_q == ST_A_DELAY) && (st_d == ST_A_RAMP1) |->
      (tmr_q == INIT_DLY_CYC - 16'h0001))
    else $error("Initial delay length wrong");

  AST_HOLD_MIN: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (st_q == ST_A_HOLD) ##1 (st_q == ST_A_RAMP2) |->
      ($past(tmr_q) >= HOLD_CYC - 16'h0001) &&
      ($past(stab_q) == VALID_CYC))
    else $error("Boot hold ended early");

  AST_ONE_STEP: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (st_q != ST_SHUT) && (st_d != ST_SHUT) && (dac_d != dac_q) |->
      step_tick && ((dac_d == dac_q + 9'h001) ||
                    (dac_d == dac_q - 9'h001)))
    else $error("DAC moved by more than one step");

  AST_NO_PAST: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    ramping && at_tgt && (st_d != ST_SHUT) |=> (dac_q == $past(dac_q)))
    else $error("Ramp moved past its target");

  AST_DRV_GATE: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    $rose(DRIVER_ENABLE) |->
      !$past(fb_high) || (st_q == ST_GOOD_WAIT) || (st_q == ST_RUN))
    else $error("Drivers enabled under a higher feedback level");

  AST_PRECHG_END: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (st_q == ST_GOOD_WAIT) |-> DRIVER_ENABLE)
    else $error("Drivers still off after soft-start");

  AST_PG_LOW: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    POWER_GOOD_FLAG |-> (st_q == ST_RUN) && $past(win_ok))
    else $error("Power-good high outside regulation");

  AST_GOOD_DELAY: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (st_q == ST_GOOD_WAIT) && (st_d == ST_RUN) |->
      (tmr_q == good_cyc - 16'h0001))
    else $error("Power-good delay length wrong");

endmodule

// File: sim/rss_far_side.sv
// Far-side model: processor code pins, output node and rate oscillator.
// Assumes the sequencer's clock and its registered DAC and driver outputs.
`timescale 1ns/100ps
module rss_far_side (
  input wire logic clk,
  input wire logic [8:0] dac,
  input wire logic drv_en,
  input wire logic [7:0] code_set,
  input wire logic [8:0] fb_set,
  output logic [7:0] voltage_id_code,
  output logic fb_above,
  output logic osc,
  output logic in_lim
);
  logic [2:0] osc_q = 3'h0;
  logic [8:0] fb_q = 9'h000;
  // The node keeps its pre-charge while undriven and trails the reference
  // by a cycle once switching, so a falling ramp reads briefly high.
  always_ff @(posedge clk) begin
    osc_q <= osc_q + 3'h1;
    fb_q <= drv_en ? dac : fb_set;
  end
  assign fb_above = fb_q > dac;
  assign osc = osc_q[2];
  assign voltage_id_code = code_set;
  assign in_lim = drv_en;
endmodule

// File: sim/rss_sequencer_test.sv
// Self-checking bench for the start-up sequencer with shortened delays.
// Assumes the far-side model drives the code, feedback and oscillator.
`timescale 1ns/100ps
module rss_sequencer_test;
  import rss_pkg::*;
  localparam int DLY = 40;
  localparam int AGD = 20;
  localparam int BST = 30;
  localparam int BGD = 50;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic lpor = 1'b0;
  logic dpor = 1'b0;
  logic en = 1'b0;
  logic gnd = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  rss_mode_e mode = RSS_MODE_A11;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic [15:0] rd_v;
  logic [7:0] code_set = 8'h00;
  logic [7:0] voltage_id_code;
  logic [8:0] fb_set = 9'h000;
  logic [8:0] dac;
  logic fb_above, osc, in_lim, drv_en, oe_n, pg;
  int n_mismatch = 0;
  int n_tests = 0;
  int c;

  rss_sequencer #(
    .INIT_DLY_CYC(16'(DLY)),
    .A_GOOD_CYC(16'(AGD)),
    .B_START_CYC(16'(BST)),
    .B_GOOD_CYC(16'(BGD))
  ) rss_sequencer_i (
    .CORE_CLK(clk),
    .RST_N(rst_n),
    .LOGIC_POR_OK(lpor),
    .DRIVER_POR_OK(dpor),
    .ENABLE_OK(en),
    .FEEDBACK_ABOVE_REF(fb_above),
    .SS_RATE_GROUNDED(gnd),
    .STEP_OSC(osc),
    .OUTPUT_IN_LIMITS(in_lim),
    .VOLTAGE_ID_CODE(voltage_id_code),
    .MODE(mode),
    .REG_ADDR(addr),
    .REG_WDATA(wdata),
    .REG_WR(wr),
    .REG_RD(rd),
    .REG_RDATA(rdata),
    .DAC_CODE(dac),
    .DRIVER_ENABLE(drv_en),
    .PWM_OE_N(oe_n),
    .POWER_GOOD_FLAG(pg)
  );

  rss_far_side rss_far_side_i (
    .clk(clk),
    .dac(dac),
    .drv_en(drv_en),
    .code_set(code_set),
    .fb_set(fb_set),
    .voltage_id_code(voltage_id_code),
    .fb_above(fb_above),
    .osc(osc),
    .in_lim(in_lim)
  );

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic results();
    if (n_mismatch == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, lo);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rd_v = rdata;
  endtask

  // Waits for the joint level of shutdown, power-good and DAC outputs.
  task automatic wait_for(input logic [10:0] v, input int lim);
    c = 0;
    while ({oe_n, pg, dac} !== v) begin
      @(posedge clk);
      #1;
      c++;
      if (c > lim) begin
        n_mismatch++;
        results();
      end
    end
  endtask

  // The code settles before the enables so that family B samples it.
  task automatic start(input rss_mode_e m, input logic [7:0] cd,
                       input logic [8:0] fb, input logic g);
    @(posedge clk);
    mode <= m;
    code_set <= cd;
    fb_set <= fb;
    gnd <= g;
    repeat (8) @(posedge clk);
    {lpor, dpor, en} <= 3'h7;
  endtask

  task automatic stop();
    @(posedge clk);
    {lpor, dpor, en} <= 3'h0;
    repeat (8) @(posedge clk);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk(oe_n, 1'b1);
    chk(pg, 1'b0);
    rd_reg(4'h1);
    chk(rd_v, 16'h0020);
    rd_reg(4'hF);
    chk(rd_v, 16'h0000);
    wr_reg(4'h0, 16'hABFE);
    rd_reg(4'h0);
    chk(rd_v, 16'h00FE);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      {lpor, dpor, en} <= ~(3'h4 >> i);
      repeat (30) @(posedge clk);
      #1;
      chk(oe_n, 1'b1);
    end
    stop();
    start(RSS_MODE_A11, 8'hCA, 9'h064, 1'b0);
    wait_for({2'h0, 9'h000}, 10);
    chk(drv_en, 1'b0);
    wait_for({2'h0, 9'h001}, DLY + 20);
    chk_rng(c, DLY, DLY + 10);
    wait_for({2'h0, 9'h002}, 20);
    chk(c, 16'h0008);
    wait_for({2'h0, 9'h050}, 800);
    chk(drv_en, 1'b0);
    wait_for({2'h0, 9'h070}, 400);
    chk(drv_en, 1'b1);
    wait_for({2'h0, 9'h0B0}, 800);
    wait_for({2'h0, 9'h0B1}, 2300);
    chk_rng(c, 2125, 2165);
    wait_for({2'h0, 9'h0C8}, 400);
    wait_for({2'h1, 9'h0C8}, AGD + 10);
    chk_rng(c, AGD, AGD + 2);
    repeat (5) @(posedge clk);
    #1;
    chk(dac, 9'h0C8);
    @(posedge clk);
    en <= 1'b0;
    wait_for({2'h2, 9'h000}, 10);
    rd_reg(4'h1);
    chk(rd_v, 16'h0020);
    stop();
    wr_reg(4'h0, 16'h0000);
    start(RSS_MODE_A10, 8'hB4, 9'h000, 1'b1);
    wait_for({2'h0, 9'h000}, 10);
    wait_for({2'h0, 9'h001}, DLY + 90);
    chk_rng(c, DLY, DLY + 77);
    wait_for({2'h0, 9'h002}, 90);
    chk(c, 16'h004B);
    stop();
    start(RSS_MODE_B6, 8'h28, 9'h1FF, 1'b0);
    wait_for({2'h0, 9'h000}, 10);
    @(posedge clk);
    code_set <= 8'h3C;
    wait_for({2'h0, 9'h001}, BST + 90);
    chk_rng(c, BST, BST + 77);
    wait_for({2'h0, 9'h002}, 90);
    chk(c, 16'h004B);
    wait_for({2'h0, 9'h014}, 1500);
    chk(drv_en, 1'b0);
    wait_for({2'h0, 9'h028}, 1500);
    wait_for({2'h1, 9'h028}, BGD + 10);
    chk_rng(c, BGD, BGD + 2);
    chk(drv_en, 1'b1);
    rd_reg(4'h2);
    chk(rd_v, 16'h0028);
    rd_reg(4'h1);
    chk(rd_v, 16'h00D8);
    stop();
    start(RSS_MODE_B5, 8'h1F, 9'h000, 1'b0);
    repeat (40) @(posedge clk);
    #1;
    chk(oe_n, 1'b1);
    @(posedge clk);
    code_set <= 8'h10;
    wait_for({2'h0, 9'h000}, 20);
    chk_rng(c, 3, 8);
    results();
  end
endmodule
